/* File: hdl/router_pkg.sv */
// Shared constants and carrier types for the addressed message router
package router_pkg;
	localparam int          CLK_HZ           = 200_000_000;
	localparam int          PROG_BAUD        = 9600;
	localparam int          CHAR_BITS        = 10;
	localparam int          PROG_CHAR_CYC    = CLK_HZ / PROG_BAUD * CHAR_BITS;
	localparam int          CYC_W            = 18;
	localparam int          HOP_W            = 4;
	localparam logic [15:0] ADDR_ALL         = 16'hffff;
	localparam logic [7:0]  START_WILD       = 8'h2a;
	localparam logic [6:0]  PAUSE_MIN        = 7'h01;
	localparam logic [6:0]  PAUSE_MAX        = 7'h64;
	localparam logic [6:0]  PAUSE_DEF        = 7'h03;
	// Address field types
	localparam logic [2:0]  ATYPE_HEX8       = 3'h6;
	localparam logic [2:0]  ATYPE_HEX16      = 3'h7;
	// Inline command bytes
	localparam logic [7:0]  CMD_S            = 8'h53;
	localparam logic [7:0]  CMD_L            = 8'h4c;
	localparam logic [7:0]  OP_CHAN          = 8'h43;
	localparam logic [7:0]  OP_PRX           = 8'h52;
	localparam logic [7:0]  OP_PTX           = 8'h54;
	localparam logic [7:0]  OP_SRX           = 8'h72;
	localparam logic [7:0]  OP_STX           = 8'h74;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL         = 8'h00;
	localparam logic [7:0]  OFS_RXADDR       = 8'h04;
	localparam logic [7:0]  OFS_TXADDR       = 8'h08;
	localparam logic [7:0]  OFS_PROTO1       = 8'h0c;
	localparam logic [7:0]  OFS_PROTO2       = 8'h10;
	localparam logic [7:0]  OFS_HOP          = 8'h14;
	localparam logic [7:0]  OFS_SERCFG       = 8'h18;
	localparam logic [7:0]  OFS_CHAN         = 8'h1c;
	localparam logic [7:0]  OFS_STATUS       = 8'h20;
	// Control register bit positions
	localparam int          CTRL_RXEN        = 0;
	localparam int          CTRL_TXEN        = 1;
	localparam int          CTRL_RPT         = 2;
	localparam int          CTRL_P1          = 3;
	localparam int          CTRL_P2          = 4;
	localparam int          CTRL_INL         = 5;
	localparam int          CTRL_PAUSE       = 8;
	// Reset values and AXI response codes
	localparam logic [31:0] CTRL_RST         = 32'h0000_0320;
	localparam logic [3:0]  HOP_RST          = 4'hf;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef struct packed {
		logic [7:0] start;
		logic [3:0] offset;
		logic [2:0] atype;
	} proto_cfg_t;

	typedef struct packed {
		logic             addressed;
		logic [15:0]      addr;
		logic [HOP_W-1:0] hop;
	} telegram_t;
endpackage

/* File: hdl/frame_gap_timer.sv */
// Serial idle-gap timer marking message boundaries in character times
`timescale 1ns/10ps
module frame_gap_timer
	import router_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic [CYC_W-1:0] char_cycles,
	input  wire logic [6:0]       pause,
	input  wire logic             byte_valid,
	output logic                  idle,
	output logic                  gap_pulse
);
	logic [CYC_W-1:0] div_r;
	logic [6:0]       chars_r;
	logic             tick;

	assign tick = (div_r >= char_cycles - 18'h00001);

	// Character-time divider, restarted by every byte
	always_ff @(posedge mclk) begin
		if (srst || byte_valid || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 18'h00001;
		end
	end

	// Idle character count and boundary pulse
	always_ff @(posedge mclk) begin
		if (srst) begin
			chars_r   <= '0;
			idle      <= 1'b1;
			gap_pulse <= 1'b0;
		end else if (byte_valid) begin
			chars_r   <= '0;
			idle      <= 1'b0;
			gap_pulse <= 1'b0;
		end else begin
			gap_pulse <= 1'b0;
			if (tick && !idle) begin
				chars_r <= chars_r + 7'h01;
				if (chars_r + 7'h01 >= pause) begin
					idle      <= 1'b1;
					gap_pulse <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: hdl/address_extractor.sv */
// Finds and decodes the address field of one user protocol
`timescale 1ns/10ps
module address_extractor
	import router_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire proto_cfg_t cfg,
	input  wire logic       sop,
	input  wire logic       byte_valid,
	input  wire logic [7:0] data,
	output logic            found,
	output logic [15:0]     addr
);
	typedef enum logic [1:0] {
		SEEK    = 2'b00,
		COLLECT = 2'b01,
		DONE    = 2'b10,
		FAIL    = 2'b11
	} ext_state_t;

	ext_state_t st_r;
	logic [4:0] pos_r;
	logic       hit;
	logic [4:0] pos;
	logic [4:0] last;
	logic       in_field;

	function automatic logic [4:0] field_len(input logic [2:0] t);
		if (t == ATYPE_HEX16) begin
			field_len = 5'd2;
		end else if (t == ATYPE_HEX8 || t == 3'h0) begin
			field_len = 5'd1;
		end else begin
			field_len = {2'b00, t};
		end
	endfunction

	// Wildcard start takes the first byte after a gap
	assign hit = (cfg.start == START_WILD) ? sop :
		((sop || st_r == SEEK) && data == cfg.start);
	assign pos      = hit ? 5'd0 : pos_r + 5'd1;
	assign last     = {1'b0, cfg.offset} + field_len(cfg.atype) - 5'd1;
	assign in_field = (pos >= {1'b0, cfg.offset}) && (pos <= last);

	// Field search and value accumulation
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r  <= SEEK;
			pos_r <= '0;
			found <= 1'b0;
			addr  <= '0;
		end else if (byte_valid && (hit || (st_r == COLLECT && !sop))) begin
			pos_r <= pos;
			st_r  <= COLLECT;
			if (hit) begin
				found <= 1'b0;
				addr  <= '0;
			end
			if (in_field) begin
				if (cfg.atype >= ATYPE_HEX8) begin
					addr <= (hit ? 16'h0000 : addr) << 8 | {8'h00, data};
				end else if (data >= 8'h30 && data <= 8'h39) begin
					addr <= 16'((hit ? 16'h0000 : addr) * 16'd10)
						+ {12'h000, data[3:0]};
				end else begin
					st_r <= FAIL;
				end
				if (pos == last && (cfg.atype >= ATYPE_HEX8 ||
					(data >= 8'h30 && data <= 8'h39))) begin
					st_r  <= DONE;
					found <= 1'b1;
				end
			end
		end else if (byte_valid && sop) begin
			st_r  <= SEEK;
			found <= 1'b0;
		end
	end
endmodule

/* File: hdl/addressed_repeater_message_router.sv */
// Message router: protocol address matching, hop count and repeat decisions
`timescale 1ns/10ps
module addressed_repeater_message_router
	import router_pkg::*;
#(
	parameter int PROG_CHAR_CYCLES = PROG_CHAR_CYC
)
(
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             cfg_entry_n,
	input  wire logic             dte_valid,
	input  wire logic [7:0]       dte_data,
	input  wire logic             rx_valid,
	input  wire telegram_t        rx_tel,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output logic                  msg_valid,
	output logic                  msg_drop,
	output telegram_t             msg_tel,
	output logic                  dte_deliver,
	output logic                  rpt_valid,
	output telegram_t             rpt_tel,
	output logic                  prog_mode,
	output logic [CYC_W-1:0]      serial_char_cycles,
	output logic [7:0]            radio_channel
);
	logic [31:0]      ctrl_r;
	logic [15:0]      primary_receive_addr;
	logic [15:0]      secondary_receive_addr;
	logic [15:0]      primary_transmit_addr;
	logic [15:0]      secondary_transmit_addr;
	proto_cfg_t       proto1_r;
	proto_cfg_t       proto2_r;
	logic [HOP_W-1:0] hop_cfg_r;
	logic [CYC_W-1:0] ser_cyc_r;
	logic [7:0]       drop_cnt_r;
	logic [7:0]       rpt_cnt_r;
	logic             aw_hold_r;
	logic             w_hold_r;
	logic [7:0]       awaddr_h_r;
	logic [31:0]      wdata_h_r;
	logic [3:0]       wstrb_h_r;
	logic             wr_go;
	logic [3:0]       wr_idx;
	logic [3:0]       rd_idx;
	logic [31:0]      rd_val;
	logic             idle;
	logic             gap_pulse;
	logic             sop;
	logic             msg_act_r;
	logic [2:0]       msg_len_r;
	logic [39:0]      cmd_sh_r;
	logic             msg_end;
	logic             is_cmd;
	logic [15:0]      cmd_val;
	logic             p1_found;
	logic             p2_found;
	logic [15:0]      p1_addr;
	logic [15:0]      p2_addr;
	logic             proto_on;
	logic [6:0]       pause;
	logic             hit_pri;
	logic             hit_sec;
	logic             accept;

	// Register index decode shared by read and write paths
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a == OFS_CTRL) begin
			reg_index = 4'h0;
		end else if (a == OFS_RXADDR) begin
			reg_index = 4'h1;
		end else if (a == OFS_TXADDR) begin
			reg_index = 4'h2;
		end else if (a == OFS_PROTO1) begin
			reg_index = 4'h3;
		end else if (a == OFS_PROTO2) begin
			reg_index = 4'h4;
		end else if (a == OFS_HOP) begin
			reg_index = 4'h5;
		end else if (a == OFS_SERCFG) begin
			reg_index = 4'h6;
		end else if (a == OFS_CHAN) begin
			reg_index = 4'h7;
		end else if (a == OFS_STATUS) begin
			reg_index = 4'h8;
		end else begin
			reg_index = 4'hf;
		end
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction

	// Clamp the pause setting into its legal range
	function automatic logic [6:0] clamp_pause(input logic [6:0] p);
		if (p < PAUSE_MIN) begin
			clamp_pause = PAUSE_MIN;
		end else if (p > PAUSE_MAX) begin
			clamp_pause = PAUSE_MAX;
		end else begin
			clamp_pause = p;
		end
	endfunction

	assign wr_go  = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wr_idx = reg_index(awaddr_h_r);
	assign rd_idx = reg_index(s_axi_araddr);
	assign pause  = clamp_pause(ctrl_r[CTRL_PAUSE +: 7]);

	// AXI4-Lite write channels, either order, response after both
	always_ff @(posedge mclk) begin
		if (srst) begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			awaddr_h_r    <= '0;
			wdata_h_r     <= '0;
			wstrb_h_r     <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r     <= 1'b1;
				awaddr_h_r    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r     <= 1'b1;
				wdata_h_r    <= s_axi_wdata;
				wstrb_h_r    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == 4'hf) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read data mux
	always_comb begin
		case (rd_idx)
			4'h0: rd_val = ctrl_r;
			4'h1: rd_val = {secondary_receive_addr, primary_receive_addr};
			4'h2: rd_val = {secondary_transmit_addr, primary_transmit_addr};
			4'h3: rd_val = {17'h00000, proto1_r};
			4'h4: rd_val = {17'h00000, proto2_r};
			4'h5: rd_val = {28'h0000000, hop_cfg_r};
			4'h6: rd_val = {14'h0000, ser_cyc_r};
			4'h7: rd_val = {24'h000000, radio_channel};
			4'h8: rd_val = {8'h00, rpt_cnt_r, drop_cnt_r, 7'h00, prog_mode};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// AXI4-Lite read channel, one cycle to answer
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= (rd_idx == 4'hf) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Programming mode follows the entry pin
	always_ff @(posedge mclk) begin
		if (srst) begin
			prog_mode          <= 1'b0;
			serial_char_cycles <= CYC_W'(PROG_CHAR_CYCLES);
		end else begin
			prog_mode          <= !cfg_entry_n;
			serial_char_cycles <= prog_mode ? CYC_W'(PROG_CHAR_CYCLES)
				: ser_cyc_r;
		end
	end

	// Configuration registers, written by software or inline command
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_r                  <= CTRL_RST;
			primary_receive_addr    <= '0;
			secondary_receive_addr  <= '0;
			primary_transmit_addr   <= '0;
			secondary_transmit_addr <= '0;
			proto1_r                <= '0;
			proto2_r                <= '0;
			hop_cfg_r               <= HOP_RST;
			ser_cyc_r               <= CYC_W'(PROG_CHAR_CYCLES);
			radio_channel           <= '0;
		end else if (wr_go) begin
			case (wr_idx)
				4'h0: ctrl_r <= merge(ctrl_r, wdata_h_r, wstrb_h_r);
				4'h1: {secondary_receive_addr, primary_receive_addr} <= merge(
					{secondary_receive_addr, primary_receive_addr},
					wdata_h_r, wstrb_h_r);
				4'h2: {secondary_transmit_addr, primary_transmit_addr} <= merge(
					{secondary_transmit_addr, primary_transmit_addr},
					wdata_h_r, wstrb_h_r);
				4'h3: proto1_r <= 15'(merge({17'h0, proto1_r}, wdata_h_r, wstrb_h_r));
				4'h4: proto2_r <= 15'(merge({17'h0, proto2_r}, wdata_h_r, wstrb_h_r));
				4'h5: if (prog_mode) begin
					hop_cfg_r <= wstrb_h_r[0] ? wdata_h_r[3:0] : hop_cfg_r;
				end
				4'h6: if (prog_mode) begin
					ser_cyc_r <= CYC_W'(merge({14'h0, ser_cyc_r}, wdata_h_r, wstrb_h_r));
				end
				4'h7: radio_channel <= wstrb_h_r[0] ? wdata_h_r[7:0] : radio_channel;
				default: ;
			endcase
		end else if (msg_end && is_cmd) begin
			case (cmd_sh_r[23:16])
				OP_CHAN: radio_channel           <= cmd_val[7:0];
				OP_PRX:  primary_receive_addr    <= cmd_val;
				OP_PTX:  primary_transmit_addr   <= cmd_val;
				OP_SRX:  secondary_receive_addr  <= cmd_val;
				OP_STX:  secondary_transmit_addr <= cmd_val;
				default: ;
			endcase
		end
	end

	frame_gap_timer u_gap (
		.mclk        (mclk),
		.srst        (srst),
		.char_cycles (serial_char_cycles),
		.pause       (pause),
		.byte_valid  (dte_valid),
		.idle        (idle),
		.gap_pulse   (gap_pulse)
	);

	address_extractor u_proto1 (
		.mclk       (mclk),
		.srst       (srst),
		.cfg        (proto1_r),
		.sop        (sop),
		.byte_valid (dte_valid),
		.data       (dte_data),
		.found      (p1_found),
		.addr       (p1_addr)
	);

	address_extractor u_proto2 (
		.mclk       (mclk),
		.srst       (srst),
		.cfg        (proto2_r),
		.sop        (sop),
		.byte_valid (dte_valid),
		.data       (dte_data),
		.found      (p2_found),
		.addr       (p2_addr)
	);

	assign sop      = dte_valid && idle;
	assign msg_end  = gap_pulse && msg_act_r;
	assign cmd_val  = cmd_sh_r[15:0];
	assign is_cmd   = ctrl_r[CTRL_INL] && !prog_mode && msg_len_r == 3'd5 &&
		cmd_sh_r[39:32] == CMD_S && cmd_sh_r[31:24] == CMD_L;
	assign proto_on = ctrl_r[CTRL_P1] || ctrl_r[CTRL_P2];

	// Message length and last five bytes for inline command detection
	always_ff @(posedge mclk) begin
		if (srst || msg_end) begin
			msg_act_r <= 1'b0;
			msg_len_r <= '0;
			cmd_sh_r  <= '0;
		end else if (dte_valid) begin
			msg_act_r <= 1'b1;
			msg_len_r <= sop ? 3'd1 : (msg_len_r == 3'd7 ? 3'd7 : msg_len_r + 3'd1);
			cmd_sh_r  <= sop ? {32'h0, dte_data} : {cmd_sh_r[31:0], dte_data};
		end
	end

	// Outgoing message routing at each message boundary
	always_ff @(posedge mclk) begin
		if (srst) begin
			msg_valid  <= 1'b0;
			msg_drop   <= 1'b0;
			msg_tel    <= '0;
			drop_cnt_r <= '0;
		end else begin
			msg_valid <= 1'b0;
			msg_drop  <= 1'b0;
			if (msg_end && !is_cmd) begin
				msg_tel.addressed <= ctrl_r[CTRL_TXEN];
				msg_tel.hop <= ctrl_r[CTRL_TXEN] ? hop_cfg_r : '0;
				if (!proto_on) begin
					msg_valid    <= 1'b1;
					msg_tel.addr <= primary_transmit_addr;
				end else if (ctrl_r[CTRL_P1] && p1_found) begin
					msg_valid    <= 1'b1;
					msg_tel.addr <= p1_addr;
				end else if (ctrl_r[CTRL_P2] && p2_found) begin
					msg_valid    <= 1'b1;
					msg_tel.addr <= p2_addr;
				end else begin
					msg_drop   <= 1'b1;
					drop_cnt_r <= drop_cnt_r + 8'h01;
				end
			end
		end
	end

	// Received telegram address check; all-ones accepts everything
	assign hit_pri = rx_tel.addr == primary_receive_addr ||
		primary_receive_addr == ADDR_ALL;
	assign hit_sec = rx_tel.addr == secondary_receive_addr ||
		secondary_receive_addr == ADDR_ALL;
	assign accept  = !rx_tel.addressed || !ctrl_r[CTRL_RXEN] ||
		hit_pri || hit_sec;

	// Local delivery and repeat decision
	always_ff @(posedge mclk) begin
		if (srst) begin
			dte_deliver <= 1'b0;
			rpt_valid   <= 1'b0;
			rpt_tel     <= '0;
			rpt_cnt_r   <= '0;
		end else begin
			dte_deliver <= rx_valid && accept;
			rpt_valid   <= 1'b0;
			if (rx_valid && accept && ctrl_r[CTRL_RPT]) begin
				rpt_tel.addressed <= rx_tel.addressed;
				rpt_tel.addr <= (ctrl_r[CTRL_RXEN] && rx_tel.addressed && hit_sec && !hit_pri)
					? secondary_transmit_addr : primary_transmit_addr;
				if (!rx_tel.addressed) begin
					rpt_valid   <= 1'b1;
					rpt_tel.hop <= '0;
					rpt_cnt_r   <= rpt_cnt_r + 8'h01;
				end else if (rx_tel.hop >= 4'd2) begin
					rpt_valid   <= 1'b1;
					rpt_tel.hop <= rx_tel.hop - 4'd1;
					rpt_cnt_r   <= rpt_cnt_r + 8'h01;
				end
			end
		end
	end

	a_hop_decrement: assert property (@(posedge mclk) disable iff (srst)
		rx_valid && accept && ctrl_r[CTRL_RPT] && rx_tel.addressed && rx_tel.hop >= 4'd2
		|=> rpt_valid && rpt_tel.hop == $past(rx_tel.hop) - 4'd1)
		else $error("repeat hop not decremented");
	a_low_hop_hold: assert property (@(posedge mclk) disable iff (srst)
		rx_valid && rx_tel.addressed && rx_tel.hop < 4'd2 |=> !rpt_valid)
		else $error("low hop telegram repeated");
	a_discard_nomatch: assert property (@(posedge mclk) disable iff (srst)
		rx_valid && rx_tel.addressed && ctrl_r[CTRL_RXEN] && !hit_pri && !hit_sec
		|=> !dte_deliver && !rpt_valid)
		else $error("unmatched telegram passed");
	a_all_ones_accept: assert property (@(posedge mclk) disable iff (srst)
		rx_valid && primary_receive_addr == ADDR_ALL |=> dte_deliver)
		else $error("broadcast address not accepted");
	a_secondary_tx: assert property (@(posedge mclk) disable iff (srst)
		rpt_valid && rpt_tel.addressed && $past(ctrl_r[CTRL_RXEN]) && !$past(hit_sec)
		|-> rpt_tel.addr == $past(primary_transmit_addr))
		else $error("secondary address used wrongly");
	a_drop_unmatched: assert property (@(posedge mclk) disable iff (srst)
		msg_end && !is_cmd && proto_on && !(ctrl_r[CTRL_P1] && p1_found) &&
		!(ctrl_r[CTRL_P2] && p2_found) |=> msg_drop && !msg_valid)
		else $error("unmatched message not dropped");
	a_proto_order: assert property (@(posedge mclk) disable iff (srst)
		msg_end && !is_cmd && ctrl_r[CTRL_P1] && p1_found
		|=> msg_valid && msg_tel.addr == $past(p1_addr))
		else $error("protocol 1 not preferred");
	a_hop_field: assert property (@(posedge mclk) disable iff (srst)
		msg_valid && msg_tel.addressed |-> msg_tel.hop == hop_cfg_r)
		else $error("hop field missing");
	a_prog_rate: assert property (@(posedge mclk) disable iff (srst)
		prog_mode ##1 prog_mode |-> serial_char_cycles == CYC_W'(PROG_CHAR_CYCLES))
		else $error("programming rate not used");
endmodule

/* File: sim/peer_model.sv */
// Terminal and peer radio model driving the router's far-side inputs
`timescale 1ns/10ps
module peer_model
	import router_pkg::*;
(
	input  wire logic  mclk,
	output logic       dte_valid,
	output logic [7:0] dte_data,
	output logic       rx_valid,
	output telegram_t  rx_tel
);
	initial begin
		dte_valid = 1'b0;
		dte_data = 8'h00;
		rx_valid = 1'b0;
		rx_tel = '0;
	end
	// One byte, well inside the pause; line scrambled after
	task automatic send_byte(input logic [7:0] b);
		@(posedge mclk);
		dte_valid <= 1'b1;
		dte_data <= b;
		@(posedge mclk);
		dte_valid <= 1'b0;
		dte_data <= ~b;
	endtask
	// One received radio telegram
	task automatic send_tel(input telegram_t t);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_tel <= t;
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_tel <= ~t;
	endtask
endmodule

/* File: sim/tb_addressed_repeater_message_router.sv */
// Self-checking bench for the addressed message router
`timescale 1ns/10ps
module tb_addressed_repeater_message_router;
	import router_pkg::*;
	logic             mclk, srst, cfg_entry_n, dte_valid, rx_valid, msg_valid, msg_drop;
	logic             dte_deliver, rpt_valid, prog_mode, s_axi_awvalid, s_axi_awready;
	logic             s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic             s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]       dte_data, s_axi_awaddr, s_axi_araddr, radio_channel;
	logic [31:0]      s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp, res;
	logic [CYC_W-1:0] serial_char_cycles;
	telegram_t        rx_tel, msg_tel, rpt_tel;
	int               fail_count, checks;

	addressed_repeater_message_router #(.PROG_CHAR_CYCLES(20))
		i_addressed_repeater_message_router (
		.mclk(mclk), .srst(srst), .cfg_entry_n(cfg_entry_n),
		.dte_valid(dte_valid), .dte_data(dte_data),
		.rx_valid(rx_valid), .rx_tel(rx_tel),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .msg_valid(msg_valid),
		.msg_drop(msg_drop), .msg_tel(msg_tel),
		.dte_deliver(dte_deliver), .rpt_valid(rpt_valid),
		.rpt_tel(rpt_tel), .prog_mode(prog_mode),
		.serial_char_cycles(serial_char_cycles),
		.radio_channel(radio_channel));
	peer_model i_peer_model (.mclk(mclk), .dte_valid(dte_valid), .dte_data(dte_data),
		.rx_valid(rx_valid), .rx_tel(rx_tel));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// AXI4-Lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				res = s_axi_bresp;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rdv = s_axi_rdata;
				res = s_axi_rresp;
				break;
			end
		end
	endtask
	// Radio telegram in; e = {deliver, repeat}, r = {addressed, repeat addr, hop}
	task automatic rxt(input telegram_t t, input logic [1:0] e, input logic [20:0] r);
		i_peer_model.send_tel(t);
		#1;
		chk("deliver_repeat", {30'h0, e}, {30'h0, dte_deliver, rpt_valid});
		if (e[0]) chk("repeat_tel", {11'h0, r}, {11'h0, rpt_tel});
	endtask
	// Terminal message in; e = {sent, dropped}
	task automatic msg(input logic [39:0] b, input int n, input logic [1:0] e,
		input logic [20:0] t);
		for (int i = n - 1; i >= 0; i--) i_peer_model.send_byte(b[i*8 +: 8]);
		res = 2'b00;
		repeat (400) begin
			@(posedge mclk);
			#1;
			if (msg_valid || msg_drop) begin
				res = {msg_valid, msg_drop};
				break;
			end
		end
		chk("msg_result", {30'h0, e}, {30'h0, res});
		if (e[1]) chk("msg_tel", {11'h0, t}, {11'h0, msg_tel});
	endtask
	task automatic conclude;
		$display("Checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog far beyond the 2700 or so cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		conclude();
	end
	initial begin
		{srst, cfg_entry_n, s_axi_wstrb} = 6'h3f;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rd(OFS_CTRL);
		chk("ctrl", CTRL_RST, rdv);
		rd(8'h40);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, res});
		chk("unmapped_data", 32'h0, rdv);
		wr(8'h44, 32'h0000_0001);
		chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, res});
		$display("Register test done");
		wr(OFS_RXADDR, 32'h0055_0020);
		wr(OFS_TXADDR, 32'h0077_0066);
		wr(OFS_CTRL, 32'h0000_0327); // Repeater on from here
		rxt('{1'b1, 16'h0020, 4'h3}, 2'b11, 21'h1_0066_2);
		rxt('{1'b1, 16'h0020, 4'h1}, 2'b10, 21'h0);
		rxt('{1'b1, 16'h0020, 4'h0}, 2'b10, 21'h0);
		rxt('{1'b1, 16'h0099, 4'h3}, 2'b00, 21'h0);
		rxt('{1'b0, 16'h0099, 4'h3}, 2'b11, 21'h0_0066_0);
		rxt('{1'b1, 16'h0055, 4'h2}, 2'b11, 21'h1_0077_1);
		wr(OFS_RXADDR, 32'h0055_ffff);
		rxt('{1'b1, 16'h1234, 4'hf}, 2'b11, 21'h1_0066_e);
		$display("Radio test done");
		msg(40'h01_02_03, 3, 2'b10, 21'h1_0066_f);
		wr(OFS_PROTO1, 32'h0000_150e);
		wr(OFS_CTRL, 32'h0000_032f);
		msg(40'h11_42_99, 3, 2'b10, 21'h1_0042_f);
		wr(OFS_PROTO1, 32'h0000_1d0e);
		wr(OFS_PROTO2, 32'h0000_1506);
		wr(OFS_CTRL, 32'h0000_033f);
		msg(40'h3a_07_01, 3, 2'b10, 21'h1_0007_f);
		msg(40'h10_20_30, 3, 2'b10, 21'h1_0010_f);
		wr(OFS_CTRL, 32'h0000_032f);
		msg(40'h10_20_30, 3, 2'b01, 21'h0);
		wr(OFS_PROTO1, 32'h0000_1d0a); // Two ASCII digits at offset 1
		msg(40'h3a_31_30, 3, 2'b10, 21'h1_000a_f);
		msg(40'h53_4c_43_00_05, 5, 2'b00, 21'h0);
		chk("channel", 32'h5, {24'h0, radio_channel});
		msg(40'h53_4c_54_12_34, 5, 2'b00, 21'h0);
		msg(40'h53_4c_74_56_78, 5, 2'b00, 21'h0);
		msg(40'h53_4c_52_0a_bc, 5, 2'b00, 21'h0);
		msg(40'h53_4c_72_0d_ef, 5, 2'b00, 21'h0);
		rd(OFS_TXADDR);
		chk("tx_addr", 32'h5678_1234, rdv);
		rd(OFS_RXADDR);
		chk("rx_addr", 32'h0def_0abc, rdv);
		$display("Message test done");
		wr(OFS_HOP, 32'h0000_0005); // Refused outside programming mode
		rd(OFS_HOP);
		chk("hop_locked", 32'hf, rdv);
		@(posedge mclk);
		cfg_entry_n <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("prog_mode", 32'h1, {31'h0, prog_mode});
		wr(OFS_SERCFG, 32'h0000_001e);
		wr(OFS_HOP, 32'h0000_0005);
		repeat (4) @(posedge mclk);
		chk("prog_cycles", 32'h14, {14'h0, serial_char_cycles});
		cfg_entry_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("char_cycles", 32'h1e, {14'h0, serial_char_cycles});
		msg(40'h3a_30_39, 3, 2'b10, 21'h1_0009_5);
		rd(OFS_STATUS);
		chk("status", 32'h0004_0100, rdv);
		$display("Programming test done");
		conclude();
	end
endmodule
